// *** src/tcs_map.svh ***
// Constants for the tunable capacitor serial control port.
// Function
// - Sample data on each serial clock rise.
// - Words travel most significant bit first.
// - Enable fall applies shifted word as state.
// - No bit count; keep last eight bits.
// - Respond only to transfers framed by enable.
// - Bit five high means standby, low active.
// - Bits four to zero form capacitance state.
// - State zero minimum, all ones maximum capacitance.
// - New capacitance settles within twelve microseconds.
// - Standby to active reaches performance in seventy.
`ifndef TCS_MAP_SVH
`define TCS_MAP_SVH

// ======================================================================
// Control word layout
`define TCS_WORD_W 8
`define TCS_CAP_W 5
`define TCS_STANDBY_BIT 5
`define TCS_CAP_MSB 4
`define TCS_CAP_LSB 0
`define TCS_WORD_RESET 8'h00

// ======================================================================
// Timing
`define TCS_REF_MHZ 50
`define TCS_SETTLE_US 12
`define TCS_WAKE_US 70
`define TCS_SETTLE_CYC (`TCS_SETTLE_US * `TCS_REF_MHZ)
`define TCS_WAKE_CYC (`TCS_WAKE_US * `TCS_REF_MHZ)
`define TCS_CNT_W 12

`endif

// *** src/tcs_pkg.sv ***
// Types shared by the tunable capacitor serial control port.
package tcs_pkg;

    // ==================================================================
    // Control word as received, most significant field first.
    typedef struct packed {
        logic [1:0] reserved;
        logic standby;
        logic [4:0] cap_state;
    } tcs_word_s;

    // ==================================================================
    // Settling tracker states.
    typedef enum logic [1:0] {
        TCS_SETTLED = 2'b00,
        TCS_SETTLE = 2'b01,
        TCS_WAKE = 2'b10
    } tcs_track_e;

endpackage

// *** src/tcs_sync.sv ***
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module tcs_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Asynchronous inputs and their synchronised copies.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // Refuse a group with no members.
    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("tcs_sync needs at least one bit");
        end
    endgenerate

    // The first stage feeds only the second stage.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule

// *** src/tcs_serial_ctrl.sv ***
// Write-only three-wire serial control port of a tunable capacitor.
`timescale 1ns/1ps
`include "tcs_map.svh"
module tcs_serial_ctrl
    import tcs_pkg::*;
#(
    parameter int CNT_W = `TCS_CNT_W
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Serial pins from the master.
    input wire logic serial_latch_enable,
    input wire logic serial_clock,
    input wire logic serial_data,
    // Applied control state.
    output logic [4:0] cap_state,
    output logic standby_select,
    output logic tuning_settled
);

    // ==================================================================
    // Parameter check
    localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(`TCS_SETTLE_CYC - 1);
    localparam logic [CNT_W-1:0] WAKE_LOAD = CNT_W'(`TCS_WAKE_CYC - 1);
    localparam int SETTLE_MAX = `TCS_SETTLE_CYC + 1;

    generate
        if ((2 ** CNT_W) < `TCS_WAKE_CYC) begin : g_bad_cnt
            $error("CNT_W too narrow for the wake time");
        end
    endgenerate

    // ==================================================================
    // Pin synchronisation and edge detection
    logic [2:0] pins_s;
    logic en_s;
    logic clk_s;
    logic data_s;
    logic en_d_r;
    logic clk_d_r;
    logic en_d_nxt;
    logic clk_d_nxt;
    logic clk_rise;
    logic en_fall;

    tcs_sync #(
        .WIDTH(3)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .async_in({serial_latch_enable, serial_clock, serial_data}),
        .sync_out(pins_s)
    );

    assign en_s = pins_s[2];
    assign clk_s = pins_s[1];
    assign data_s = pins_s[0];

    // Previous pin levels for edge finding.
    always_comb begin
        en_d_nxt = en_s;
        clk_d_nxt = clk_s;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            en_d_r <= 1'b0;
            clk_d_r <= 1'b0;
        end else begin
            en_d_r <= en_d_nxt;
            clk_d_r <= clk_d_nxt;
        end
    end

    // Clock and data share one synchroniser delay, so data is sampled as at the pin.
    assign clk_rise = clk_s & ~clk_d_r;
    assign en_fall = ~en_s & en_d_r;

    // ==================================================================
    // Shift register and applied word
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    tcs_word_s word_r;
    tcs_word_s word_nxt;

    // Shift only inside an enable frame, newest bit at the bottom.
    always_comb begin
        shift_nxt = shift_r;
        word_nxt = word_r;
        if (clk_rise && en_s) begin
            shift_nxt = {shift_r[6:0], data_s};
        end
        if (en_fall) begin
            word_nxt = tcs_word_s'(shift_r);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_r <= `TCS_WORD_RESET;
            word_r <= tcs_word_s'(`TCS_WORD_RESET);
        end else begin
            shift_r <= shift_nxt;
            word_r <= word_nxt;
        end
    end

    assign cap_state = word_r.cap_state;
    assign standby_select = word_r.standby;

    // ==================================================================
    // Settling tracker
    tcs_track_e state_r;
    tcs_track_e state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic settled_r;
    logic settled_nxt;
    tcs_word_s new_word;
    logic waking;
    logic changing;
    logic retune;

    assign new_word = tcs_word_s'(shift_r);
    assign waking = word_r.standby & ~new_word.standby;
    assign changing = (new_word.cap_state != word_r.cap_state) |
        (new_word.standby != word_r.standby);

    // A new applied change restarts or lengthens a wait in progress, but a change that is not a wake leaves a running wake wait as it is.
    assign retune = en_fall & (changing | waking);

    // A wake from standby takes the longer wait; any other change the shorter, except during a wake wait, which keeps counting.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            TCS_SETTLED: begin
            end
            TCS_SETTLE, TCS_WAKE: begin
                if (cnt_r == '0) begin
                    state_nxt = TCS_SETTLED;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
        endcase
        if (en_fall && waking) begin
            state_nxt = TCS_WAKE;
            cnt_nxt = WAKE_LOAD;
        end else if (en_fall && changing && state_r != TCS_WAKE) begin
            state_nxt = TCS_SETTLE;
            cnt_nxt = SETTLE_LOAD;
        end
        settled_nxt = (state_nxt == TCS_SETTLED);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= TCS_SETTLED;
            cnt_r <= '0;
            settled_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            settled_r <= settled_nxt;
        end
    end

    assign tuning_settled = settled_r;

    // ==================================================================
    // Assertions
    a_shift_msb_first: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_rise && en_s) |=> (shift_r == {$past(shift_r[6:0]), $past(data_s)}))
        else $error("shift register did not take the sampled bit");

    a_no_shift_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (!en_s || !clk_rise) |=> $stable(shift_r))
        else $error("shift register moved outside a clock rise in frame");

    a_apply_on_fall: assert property (@(posedge ref_clk) disable iff (!rst_b)
        en_fall |=> (word_r == $past(shift_r)))
        else $error("word not applied on enable fall");

    a_hold_between: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !en_fall |=> $stable(word_r))
        else $error("applied word changed without enable fall");

    a_standby_map: assert property (@(posedge ref_clk) disable iff (!rst_b)
        en_fall |=> (standby_select == $past(shift_r[`TCS_STANDBY_BIT])))
        else $error("standby output not from bit five");

    a_cap_map: assert property (@(posedge ref_clk) disable iff (!rst_b)
        en_fall |=> (cap_state == $past(shift_r[`TCS_CAP_MSB:`TCS_CAP_LSB])))
        else $error("capacitance state not from bits four to zero");

    a_settle_bound: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (en_fall && changing && !waking && state_r == TCS_SETTLED)
        |=> !tuning_settled ##[1:SETTLE_MAX] (tuning_settled || retune))
        else $error("settling window wrong length");

    a_settle_start: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (en_fall && changing && !waking && state_r != TCS_WAKE)
        |=> (state_r == TCS_SETTLE && cnt_r == SETTLE_LOAD && !tuning_settled))
        else $error("settle wait not started");

    a_settle_exit: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (state_r == TCS_SETTLE && cnt_r == '0 && !en_fall) |=> tuning_settled)
        else $error("settle wait did not end");

    a_wake_exit: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (state_r == TCS_WAKE && cnt_r == '0 && !en_fall) |=> tuning_settled)
        else $error("wake wait did not end");

    a_no_change_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (en_fall && !changing && state_r == TCS_SETTLED) |=> tuning_settled)
        else $error("unchanged word started a wait");

    a_wake_count: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (en_fall && waking) |=> (state_r == TCS_WAKE && cnt_r == WAKE_LOAD && !tuning_settled))
        else $error("wake wait not started");

    a_last_eight: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_rise && en_s) |=> (shift_r[0] == $past(data_s) && shift_r[7:1] == $past(shift_r[6:0])))
        else $error("older bits not kept in order");

endmodule

// *** verif/tcs_master.sv ***
// Serial master model that drives the latch enable, clock and data pins.
`timescale 1ns/1ps
module tcs_master (
    // Pacing clock.
    input wire logic ref_clk,
    // Serial pins towards the port.
    output logic serial_latch_enable,
    output logic serial_clock,
    output logic serial_data
);
    // =================================================================
    // Pins idle with enable and clock low; the clock stands still between frames except in a send with frame 0.
    initial begin
        serial_latch_enable = 1'b0;
        serial_clock = 1'b0;
        serial_data = 1'b0;
    end

    // Shifts n bits, most significant first, with h reference cycles per half period.
    // A frame of 0 toggles the clock while the enable stays low.
    task automatic send(input logic [15:0] w, input int n, input int h, input bit frame);
        repeat (2) @(negedge ref_clk);
        serial_latch_enable = frame;
        repeat (h) @(negedge ref_clk);
        for (int i = n - 1; i >= 0; i--) begin
            serial_data = w[i];
            repeat (h) @(negedge ref_clk);
            serial_clock = 1'b1;
            repeat (h) @(negedge ref_clk);
            serial_clock = 1'b0;
        end
        repeat (h) @(negedge ref_clk);
        serial_latch_enable = 1'b0;
        serial_data = ~serial_data;
    endtask
endmodule

// *** verif/tcs_serial_ctrl_tb_top.sv ***
// Self-checking bench for the tunable capacitor serial control port.
`timescale 1ns/1ps
module tcs_serial_ctrl_tb_top;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic serial_latch_enable;
    logic serial_clock;
    logic serial_data;
    logic [4:0] cap_state;
    logic standby_select;
    logic tuning_settled;
    int n_mismatch = 0;
    int tests_run = 0;

    // =================================================================
    // Reference clock at 50 MHz.
    always #10 ref_clk = ~ref_clk;

    tcs_master u_tcs_master (
        .ref_clk(ref_clk),
        .serial_latch_enable(serial_latch_enable),
        .serial_clock(serial_clock),
        .serial_data(serial_data)
    );

    tcs_serial_ctrl u_tcs_serial_ctrl (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .serial_latch_enable(serial_latch_enable),
        .serial_clock(serial_clock),
        .serial_data(serial_data),
        .cap_state(cap_state),
        .standby_select(standby_select),
        .tuning_settled(tuning_settled)
    );

    // =================================================================
    // Compares a value with its expectation and counts both.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Sends one framed word and lets the applied state land.
    task automatic put(input logic [15:0] w, input int n, input int h);
        u_tcs_master.send(w, n, h, 1'b1);
        repeat (6) @(negedge ref_clk);
    endtask

    // Applied state assembled in control word order.
    function automatic logic [7:0] st();
        return {2'b00, standby_select, cap_state};
    endfunction

    // Checks the state left by reset.
    task automatic t_reset();
        chk(st(), 8'h00);
        chk({7'h00, tuning_settled}, 8'h01);
    endtask

    // Writes a state and follows the settling wait.
    task automatic t_settle();
        put(16'h0015, 8, 4);
        chk(st(), 8'h15);
        chk({7'h00, tuning_settled}, 8'h00);
        repeat (500) @(negedge ref_clk);
        chk({7'h00, tuning_settled}, 8'h00);
        repeat (200) @(negedge ref_clk);
        chk({7'h00, tuning_settled}, 8'h01);
    endtask

    // Enters standby at maximum state, then wakes at minimum.
    task automatic t_wake();
        put(16'h003f, 8, 4);
        chk(st(), 8'h3f);
        repeat (700) @(negedge ref_clk);
        put(16'h0000, 8, 4);
        chk(st(), 8'h00);
        repeat (3300) @(negedge ref_clk);
        chk({7'h00, tuning_settled}, 8'h00);
        repeat (300) @(negedge ref_clk);
        chk({7'h00, tuning_settled}, 8'h01);
    endtask

    // Leading extra bits are dropped; unframed clocks change nothing.
    task automatic t_extra();
        put(16'h0f0a, 12, 4);
        chk(st(), 8'h0a);
        u_tcs_master.send(16'h001f, 8, 4, 1'b0);
        repeat (6) @(negedge ref_clk);
        chk(st(), 8'h0a);
        u_tcs_master.send(16'h0000, 0, 4, 1'b1);
        repeat (6) @(negedge ref_clk);
        chk(st(), 8'h0a);
    endtask

    // Reset in mid-settle restores the reset state; a frame after it still works.
    task automatic t_rerst();
        rst_b = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(st(), 8'h00);
        chk({7'h00, tuning_settled}, 8'h01);
        rst_b = 1'b1;
        repeat (5) @(negedge ref_clk);
        chk(st(), 8'h00);
        chk({7'h00, tuning_settled}, 8'h01);
        put(16'h0007, 8, 4);
        chk(st(), 8'h07);
    endtask

    // =================================================================
    // Main sequence: reset for 20 cycles, then the scenarios.
    initial begin
        repeat (20) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (5) @(negedge ref_clk);
        t_reset();
        t_settle();
        t_wake();
        t_extra();
        t_rerst();
        stop_test();
    end

    // Watchdog well beyond the expected run of about 6000 cycles.
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        stop_test();
    end
endmodule
